//--- rtl/cdmr_pkg.sv
/*
 * Shared constants for the compatibility dataset read server: dataset
 * geometry, frame addresses, function and exception codes, CRC setup.
 * Assumes a byte-oriented serial front end that delimits frames.
 */
package cdmr_pkg;

    // ------------------------------------------------------------
    // dataset geometry
    // ------------------------------------------------------------
    localparam logic [15:0] DS_FIRST_REG = 16'h2EE0;   // register number 12000
    localparam logic [15:0] DS_LAST_REG = 16'h2F85;    // register number 12165
    localparam logic [15:0] DS_BASE_ADDR = 16'h2EDF;   // frame address of 12000
    localparam int DS_WORDS = 166;
    localparam logic [15:0] PHASE1_CURRENT_RMS_ADDR = 16'h2EEF;
    localparam logic [15:0] REACTIVE_ENERGY_TOTAL_ADDR = 16'h2F13;
    localparam logic [7:0] PHASE1_CURRENT_RMS_IDX = 8'h10;
    localparam logic [7:0] REACTIVE_ENERGY_TOTAL_IDX = 8'h34;

    // ------------------------------------------------------------
    // frame layout and codes
    // ------------------------------------------------------------
    localparam logic [3:0] REQ_LEN = 4'h8;
    localparam logic [3:0] POS_DEV = 4'h0;
    localparam logic [3:0] POS_FC = 4'h1;
    localparam logic [3:0] POS_START_HI = 4'h2;
    localparam logic [3:0] POS_START_LO = 4'h3;
    localparam logic [3:0] POS_CNT_HI = 4'h4;
    localparam logic [3:0] POS_CNT_LO = 4'h5;
    localparam logic [8:0] RSP_HDR_LEN = 9'h003;
    localparam logic [7:0] FC_READ_HOLDING = 8'h03;
    localparam logic [7:0] EXC_FLAG = 8'h80;
    localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
    localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
    localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
    localparam logic [15:0] MAX_READ_COUNT = 16'h007D;
    localparam logic [7:0] BROADCAST_ADDR = 8'h00;

    // ------------------------------------------------------------
    // crc
    // ------------------------------------------------------------
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'hA001;
    localparam logic [15:0] CRC_GOOD = 16'h0000;

    typedef enum logic [1:0] {
        CDMR_ST_RX = 2'b00,
        CDMR_ST_CHECK = 2'b01,
        CDMR_ST_SEND = 2'b10
    } cdmr_state_t;

endpackage : cdmr_pkg

//--- rtl/cdmr_crc16.sv
/*
 * One-byte step of the reflected serial-line CRC-16.
 * Purely combinational; the caller holds the running value.
 */
module cdmr_crc16
(
    // running value in and out
    input wire logic [15:0] crc_i,
    input wire logic [7:0] byte_i,
    output logic [15:0] crc_o
);
    import cdmr_pkg::*;

    always_comb
    begin
        logic [15:0] c;
        c = crc_i ^ {8'h00, byte_i};
        for (int b = 0; b < 8; b++)
        begin
            if (c[0])
            begin
                c = (c >> 1) ^ CRC_POLY;
            end
            else
            begin
                c = c >> 1;
            end
        end
        crc_o = c;
    end
endmodule // cdmr_crc16

//--- rtl/cdmr_reader.sv
/*
 * Read-holding-registers server for the compatibility dataset: collects
 * request bytes, checks CRC and slave address, range-checks, then streams
 * the answer or an exception. Internal measurement units refresh words.
 * Assumes rx bytes and the end-of-frame pulse come from same-clock logic
 * that already detected the inter-frame silence.
 */
//
// What this block does
// - dataset occupies register numbers 12000 to 12165, readable in two requests.
// - measurement units refresh dataset words at any time, independent of requests.
// - dataset reads answered from on-chip words; latency grows one cycle per register read.
// - whole common table from 12000 (113 registers) fits one request.
// - frame address equals register number minus one.
// - register 12000 sits at frame address 0x2EDF.
// - only Modbus read function served; command-interface registers are not.
// - words are 16 bit; 32-bit values use two unsigned words.
// - 32-bit values stored and sent most significant word first.
// - reactive energy is signed 32 bits at registers 12052 and 12053.
// - phase 1 RMS current at register 12016, frame address 0x2EEF.
// - reply echoes address and function, byte count, words high first, CRC.
// - registers unsupported by the variant are refused, never served.
module cdmr_reader
(
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // configuration
    input wire logic [7:0] slave_addr_i,
    // request byte stream
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_end_i,
    // response byte stream
    output logic tx_valid_o,
    output logic [7:0] tx_data_o,
    input wire logic tx_ready_i,
    output logic busy_o,
    // dataset refresh from measurement units
    input wire logic upd_we_i,
    input wire logic upd_pair_i,
    input wire logic upd_sup_i,
    input wire logic [7:0] upd_idx_i,
    input wire logic [31:0] upd_data_i
);
    import cdmr_pkg::*;

    typedef struct packed {
        cdmr_state_t st;
        logic [3:0] rx_cnt;
        logic rx_drop;
        logic [15:0] rx_crc;
        logic [7:0] dev;
        logic [7:0] fc;
        logic [15:0] start;
        logic [15:0] cnt;
        logic [7:0] scan_idx;
        logic [7:0] scan_left;
        logic exc;
        logic [7:0] exc_code;
        logic [8:0] k;
        logic [8:0] len;
        logic [15:0] tx_crc;
        logic tx_valid;
        logic [7:0] tx_data;
        logic busy;
    } cdmr_regs_t;

    cdmr_regs_t r_q;
    cdmr_regs_t r_d;

    // ------------------------------------------------------------
    // dataset words and support flags
    // ------------------------------------------------------------
    logic [15:0] mem_q [DS_WORDS];
    logic sup_q [DS_WORDS];

    // refresh runs regardless of protocol state; a reply may mix old and new
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < DS_WORDS; i++)
            begin
                sup_q[i] <= 1'b0;
            end
        end
        else if (ce_i && upd_we_i)
        begin
            if (upd_pair_i)
            begin
                mem_q[upd_idx_i] <= upd_data_i[31:16];
                mem_q[upd_idx_i + 8'h01] <= upd_data_i[15:0];
                sup_q[upd_idx_i] <= upd_sup_i;
                sup_q[upd_idx_i + 8'h01] <= upd_sup_i;
            end
            else
            begin
                mem_q[upd_idx_i] <= upd_data_i[15:0];
                sup_q[upd_idx_i] <= upd_sup_i;
            end
        end
    end

    // ------------------------------------------------------------
    // crc steps
    // ------------------------------------------------------------
    logic [15:0] rx_crc_next;
    logic [15:0] tx_crc_next;
    logic [7:0] tx_byte;

    cdmr_crc16 u_rx_crc (
        .crc_i(r_q.rx_crc),
        .byte_i(rx_data_i),
        .crc_o(rx_crc_next)
    );

    cdmr_crc16 u_tx_crc (
        .crc_i(r_q.tx_crc),
        .byte_i(tx_byte),
        .crc_o(tx_crc_next)
    );

    // ------------------------------------------------------------
    // response byte selection
    // ------------------------------------------------------------
    logic [15:0] first_idx;
    logic [8:0] data_pos;
    logic [7:0] word_idx;
    logic [16:0] end_idx;

    always_comb
    begin
        first_idx = r_q.start - DS_BASE_ADDR;
        data_pos = r_q.k - RSP_HDR_LEN;
        word_idx = first_idx[7:0] + data_pos[8:1];
        end_idx = {1'b0, first_idx} + {1'b0, r_q.cnt};
        case (r_q.k)
            9'h000: tx_byte = r_q.dev;
            9'h001: tx_byte = r_q.exc ? (r_q.fc | EXC_FLAG) : r_q.fc;
            9'h002: tx_byte = r_q.exc ? r_q.exc_code : {r_q.cnt[6:0], 1'b0};
            default:
            begin
                // high byte of each word first
                tx_byte = data_pos[0] ? mem_q[word_idx][7:0] : mem_q[word_idx][15:8];
            end
        endcase
    end

    // ------------------------------------------------------------
    // protocol engine
    // ------------------------------------------------------------
    always_comb
    begin
        r_d = r_q;
        case (r_q.st)
            CDMR_ST_RX:
            begin
                if (rx_end_i)
                begin
                    r_d.rx_cnt = 4'h0;
                    r_d.rx_drop = 1'b0;
                    r_d.rx_crc = CRC_INIT;
                    r_d.k = 9'h000;
                    r_d.tx_crc = CRC_INIT;
                    r_d.exc = 1'b0;
                    // bad crc, wrong length or foreign address: no answer
                    if (!r_q.rx_drop && r_q.rx_cnt == REQ_LEN && r_q.rx_crc == CRC_GOOD
                        && r_q.dev == slave_addr_i && r_q.dev != BROADCAST_ADDR)
                    begin
                        r_d.st = CDMR_ST_SEND;
                        r_d.len = RSP_HDR_LEN;
                        r_d.exc = 1'b1;
                        if (r_q.fc != FC_READ_HOLDING)
                        begin
                            r_d.exc_code = EXC_ILLEGAL_FUNC;
                        end
                        else if (r_q.cnt == 16'h0000 || r_q.cnt > MAX_READ_COUNT)
                        begin
                            r_d.exc_code = EXC_ILLEGAL_VALUE;
                        end
                        else if (r_q.start < DS_BASE_ADDR
                                 || end_idx > 17'(DS_WORDS))
                        begin
                            r_d.exc_code = EXC_ILLEGAL_ADDR;
                        end
                        else
                        begin
                            r_d.exc = 1'b0;
                            r_d.st = CDMR_ST_CHECK;
                            r_d.scan_idx = first_idx[7:0];
                            r_d.scan_left = r_q.cnt[7:0];
                        end
                    end
                end
                else if (rx_valid_i)
                begin
                    r_d.rx_crc = rx_crc_next;
                    if (r_q.rx_cnt == REQ_LEN)
                    begin
                        r_d.rx_drop = 1'b1;
                    end
                    else
                    begin
                        r_d.rx_cnt = r_q.rx_cnt + 4'h1;
                    end
                    case (r_q.rx_cnt)
                        POS_DEV: r_d.dev = rx_data_i;
                        POS_FC: r_d.fc = rx_data_i;
                        POS_START_HI: r_d.start[15:8] = rx_data_i;
                        POS_START_LO: r_d.start[7:0] = rx_data_i;
                        POS_CNT_HI: r_d.cnt[15:8] = rx_data_i;
                        POS_CNT_LO: r_d.cnt[7:0] = rx_data_i;
                        default: r_d.rx_crc = rx_crc_next;
                    endcase
                end
            end
            CDMR_ST_CHECK:
            begin
                // one word per cycle; bounded by the count limit
                if (!sup_q[r_q.scan_idx])
                begin
                    r_d.exc = 1'b1;
                    r_d.exc_code = EXC_ILLEGAL_ADDR;
                    r_d.len = RSP_HDR_LEN;
                    r_d.st = CDMR_ST_SEND;
                end
                else if (r_q.scan_left == 8'h01)
                begin
                    r_d.len = RSP_HDR_LEN + {r_q.cnt[7:0], 1'b0};
                    r_d.st = CDMR_ST_SEND;
                end
                else
                begin
                    r_d.scan_idx = r_q.scan_idx + 8'h01;
                    r_d.scan_left = r_q.scan_left - 8'h01;
                end
            end
            CDMR_ST_SEND:
            begin
                if (!r_q.tx_valid || tx_ready_i)
                begin
                    if (r_q.k < r_q.len)
                    begin
                        r_d.tx_valid = 1'b1;
                        r_d.tx_data = tx_byte;
                        r_d.tx_crc = tx_crc_next;
                        r_d.k = r_q.k + 9'h001;
                    end
                    else if (r_q.k == r_q.len)
                    begin
                        r_d.tx_valid = 1'b1;
                        r_d.tx_data = r_q.tx_crc[7:0];
                        r_d.k = r_q.k + 9'h001;
                    end
                    else if (r_q.k == r_q.len + 9'h001)
                    begin
                        r_d.tx_valid = 1'b1;
                        r_d.tx_data = r_q.tx_crc[15:8];
                        r_d.k = r_q.k + 9'h001;
                    end
                    else
                    begin
                        r_d.tx_valid = 1'b0;
                        r_d.st = CDMR_ST_RX;
                    end
                end
            end
            default:
            begin
                r_d.st = CDMR_ST_RX;
            end
        endcase
        r_d.busy = (r_d.st != CDMR_ST_RX);
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            r_q <= '0;
            r_q.st <= CDMR_ST_RX;
            r_q.rx_crc <= CRC_INIT;
            r_q.tx_crc <= CRC_INIT;
        end
        else if (ce_i)
        begin
            r_q <= r_d;
        end
    end

    assign tx_valid_o = r_q.tx_valid;
    assign tx_data_o = r_q.tx_data;
    assign busy_o = r_q.busy;
endmodule // cdmr_reader

//--- tb/cdmr_chk.sv
/*
 * Port assertions for the dataset read server.
 * Assumes a bind to cdmr_reader with ce_i held high.
 */
module cdmr_chk
(
    // clock, reset
    input wire logic clk_i,
    input wire logic rst_i,
    // watched ports
    input wire logic [7:0] slave_addr_i,
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_end_i,
    input wire logic tx_valid_o,
    input wire logic [7:0] tx_data_o,
    input wire logic tx_ready_i,
    input wire logic busy_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [63:0] req_q;
    logic [7:0] tx_cnt_q;
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // last eight request bytes, frozen while busy
    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i)
            req_q <= 64'h0;
        else if (rx_valid_i && !rx_end_i && !busy_o)
            req_q <= {req_q[55:0], rx_data_i};
    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i)
            tx_cnt_q <= 8'h00;
        else if (!busy_o)
            tx_cnt_q <= 8'h00;
        else if (tx_valid_o && tx_ready_i)
            tx_cnt_q <= tx_cnt_q + 8'h01;
    sequence s_taken;
        rx_end_i && !busy_o ##1 busy_o;
    endsequence
    AST_REPLY_TIME: assert property (s_taken |=> ##[0:128] tx_valid_o)
        else $error("reply late");
    AST_BUSY_CAUSE: assert property ($rose(busy_o) |-> $past(rx_end_i))
        else $error("busy without frame end");
    AST_VALID_IN_BUSY: assert property (tx_valid_o |-> busy_o)
        else $error("byte outside reply");
    AST_HOLD: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
        else $error("byte not held");
    AST_ECHO_ADDR: assert property ($rose(tx_valid_o) |-> tx_data_o == slave_addr_i)
        else $error("address not echoed");
    AST_ECHO_FC: assert property (tx_cnt_q == 8'h01 && tx_valid_o |->
        tx_data_o[6:0] == req_q[54:48])
        else $error("function not echoed");
    AST_FC_EXC: assert property (tx_cnt_q == 8'h01 && tx_valid_o && req_q[55:48] != 8'h03
        |-> tx_data_o == (req_q[55:48] | 8'h80))
        else $error("bad function served");
    AST_SILENT: assert property (rx_end_i && !busy_o && req_q[63:56] != slave_addr_i
        |=> !busy_o)
        else $error("foreign frame taken");
endmodule // cdmr_chk

//--- tb/cdmr_master.sv
/*
 * Master model: frames read requests with CRC and collects the reply.
 * Assumes the reader's byte streams on the same clock.
 */
module cdmr_master
(
    // clock
    input wire logic clk_i,
    // request stream
    output logic rx_valid_o,
    output logic [7:0] rx_data_o,
    output logic rx_end_o,
    // reply stream
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    output logic tx_ready_o,
    input wire logic busy_i
);
    timeunit 1ns;
    timeprecision 1ps;
    bit slow = 1'b0;
    initial
    begin
        rx_valid_o = 1'b0;
        rx_data_o = 8'h00;
        rx_end_o = 1'b0;
        tx_ready_o = 1'b0;
    end
    function automatic logic [15:0] crc(input logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (q[i])
        begin
            c ^= {8'h00, q[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        end
        return c;
    endfunction
    // bad flips one crc bit, so the frame must be dropped
    task automatic xfer(input logic [7:0] f[$], input bit bad, output logic [7:0] r[$]);
        logic [15:0] c;
        c = crc(f);
        f.push_back(c[7:0]);
        f.push_back(c[15:8] ^ {7'h00, bad});
        r = {};
        foreach (f[i])
        begin
            @(posedge clk_i);
            rx_valid_o <= 1'b1;
            rx_data_o <= f[i];
        end
        @(posedge clk_i);
        rx_valid_o <= 1'b0;
        rx_data_o <= ~f[7];
        rx_end_o <= 1'b1;
        @(posedge clk_i);
        rx_end_o <= 1'b0;
        for (int n = 0; n < 2000 && (n < 20 || busy_i !== 1'b0); n++)
        begin
            @(negedge clk_i);
            if (tx_valid_i === 1'b1 && tx_ready_o === 1'b1)
                r.push_back(tx_data_i);
            @(posedge clk_i);
            tx_ready_o <= slow ? ~tx_ready_o : 1'b1;
        end
    endtask
endmodule // cdmr_master

//--- tb/tb.sv
/*
 * Self-checking bench for the dataset read server.
 * Assumes the master model and checker from this folder.
 */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic upd_we_i = 1'b0;
    logic upd_pair_i = 1'b0;
    logic upd_sup_i = 1'b0;
    logic [7:0] upd_idx_i = 8'h00;
    logic [31:0] upd_data_i = 32'h0000_0000;
    logic rx_valid_i, rx_end_i, tx_valid_o, tx_ready_i, busy_o;
    logic [7:0] rx_data_i, tx_data_o;
    int num_errors = 0;
    int n_tests = 0;
    logic [7:0] last_r[$];
    always #5 clk_i = ~clk_i;
    cdmr_reader i_cdmr_reader (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .slave_addr_i(8'h2F), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
        .rx_end_i(rx_end_i), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
        .tx_ready_i(tx_ready_i), .busy_o(busy_o), .upd_we_i(upd_we_i),
        .upd_pair_i(upd_pair_i), .upd_sup_i(upd_sup_i), .upd_idx_i(upd_idx_i),
        .upd_data_i(upd_data_i));
    cdmr_master i_cdmr_master (.clk_i(clk_i), .rx_valid_o(rx_valid_i),
        .rx_data_o(rx_data_i), .rx_end_o(rx_end_i), .tx_valid_i(tx_valid_o),
        .tx_data_i(tx_data_o), .tx_ready_o(tx_ready_i), .busy_i(busy_o));
    task automatic stop_test();
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic fail(input logic [15:0] g, x);
        num_errors++;
        $display("BAD t=%0t got %h exp %h", $time, g, x);
    endtask
    task automatic upd(input logic [7:0] idx, input logic [31:0] d, input logic pr, sp);
        @(posedge clk_i);
        upd_we_i <= 1'b1;
        upd_idx_i <= idx;
        upd_data_i <= d;
        upd_pair_i <= pr;
        upd_sup_i <= sp;
        @(posedge clk_i);
        upd_we_i <= 1'b0;
    endtask
    // empty e means no reply at all
    task automatic run(input logic [7:0] a, fc, input logic [15:0] st, n, input bit bad,
        input logic [7:0] e[$]);
        logic [7:0] q[$];
        logic [7:0] r[$];
        logic [15:0] c;
        q = {a, fc, st[15:8], st[7:0], n[15:8], n[7:0]};
        i_cdmr_master.xfer(q, bad, r);
        last_r = r;
        c = i_cdmr_master.crc(e);
        if (e.size() > 0)
            e = {e, c[7:0], c[15:8]};
        n_tests++;
        if (r.size() != e.size())
            fail(16'(r.size()), 16'(e.size()));
        else
            foreach (e[i])
            begin
                n_tests++;
                if (r[i] !== e[i])
                    fail({8'h00, r[i]}, {8'h00, e[i]});
            end
    endtask
    task automatic exc(input logic [7:0] fc, input logic [15:0] st, n, input logic [7:0] k);
        logic [7:0] e[$];
        e = {8'h2F, fc | 8'h80, k};
        run(8'h2F, fc, st, n, 1'b0, e);
    endtask
    task automatic t_full();
        logic [7:0] e[$];
        for (int i = 0; i < 166; i++)
            upd(8'(i), {16'h0000, 8'(i), ~8'(i)}, 1'b0, 1'b1);
        e = {8'h2F, 8'h03, 8'hE2};
        for (int i = 0; i < 113; i++)
            e = {e, 8'(i), ~8'(i)};
        run(8'h2F, 8'h03, 16'h2EDF, 16'h0071, 1'b0, e);
        e = {8'h2F, 8'h03, 8'h6A};
        for (int i = 113; i < 166; i++)
            e = {e, 8'(i), ~8'(i)};
        i_cdmr_master.slow = 1'b1;
        run(8'h2F, 8'h03, 16'h2F50, 16'h0035, 1'b0, e);
        i_cdmr_master.slow = 1'b0;
    endtask
    task automatic t_values();
        logic [7:0] e[$];
        upd(8'h10, 32'h0000_022B, 1'b0, 1'b1);
        e = {8'h2F, 8'h03, 8'h02, 8'h02, 8'h2B};
        run(8'h2F, 8'h03, 16'h2EF0 - 16'h0001, 16'h0001, 1'b0, e);
        upd(8'h34, 32'hFFF2_A96E, 1'b1, 1'b1);
        e = {8'h2F, 8'h03, 8'h04, 8'hFF, 8'hF2, 8'hA9, 8'h6E};
        run(8'h2F, 8'h03, 16'h2F14 - 16'h0001, 16'h0002, 1'b0, e);
        n_tests++;
        if (last_r.size() != 9
            || $signed({last_r[3], last_r[4], last_r[5], last_r[6]}) !== -874130)
            fail({last_r[5], last_r[6]}, 16'hA96E);
    endtask
    task automatic t_refuse();
        logic [7:0] e[$];
        upd(8'h50, 32'h0000_1234, 1'b0, 1'b0);
        exc(8'h04, 16'h2EDF, 16'h0001, 8'h01);
        exc(8'h03, 16'h2EDE, 16'h0001, 8'h02);
        exc(8'h03, 16'h2F84, 16'h0002, 8'h02);
        exc(8'h03, 16'h2EDF, 16'h0000, 8'h03);
        exc(8'h03, 16'h2EDF, 16'h007E, 8'h03);
        exc(8'h03, 16'h2F2F, 16'h0001, 8'h02);
        e = {};
        run(8'h30, 8'h03, 16'h2EEF, 16'h0001, 1'b0, e);
        run(8'h00, 8'h03, 16'h2EEF, 16'h0001, 1'b0, e);
        run(8'h2F, 8'h03, 16'h2EEF, 16'h0001, 1'b1, e);
    endtask
    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_full();
        t_values();
        t_refuse();
        stop_test();
    end
    initial
    begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        stop_test();
    end
endmodule // tb
bind cdmr_reader cdmr_chk i_cdmr_chk (.clk_i(clk_i), .rst_i(rst_i),
    .slave_addr_i(slave_addr_i), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
    .rx_end_i(rx_end_i), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
    .tx_ready_i(tx_ready_i), .busy_o(busy_o));
